//--- hw/scg_pkg.sv
package scg_pkg;
    // synchroniser depth for asynchronous supply flags and pins
    localparam int SYNC_STAGES = 3;
    // channel count and default pin-to-channel mapping (fallback mode)
    localparam int NUM_CH = 8;
    localparam int NUM_IN = 2;
    localparam logic [7:0] MAP_IN0 = 8'h04;
    localparam logic [7:0] MAP_IN1 = 8'h08;
    // serial clock limits, in kHz, reported to the host
    localparam logic [15:0] SCLK_NONE_KHZ = 16'h0000;
    localparam logic [15:0] SCLK_LOW_KHZ = 16'h03e8;
    localparam logic [15:0] SCLK_FULL_KHZ = 16'h1388;
    // supply condition summary states
    typedef enum logic [3:0] {
        SCG_OFF = 4'b0001,
        SCG_CRANK = 4'b0010,
        SCG_LOW = 4'b0100,
        SCG_OK = 4'b1000
    } scg_batt_t;
endpackage

//--- hw/scg_sync_if.sv
`timescale 1ns/1ns
interface scg_sync_if;
    logic batt_crank; // battery at or below 3.0 V
    logic batt_uv; // battery under undervoltage threshold
    logic batt_op; // battery at or above operating threshold
    logic logic_uv; // logic supply in undervoltage
    logic logic_lop; // logic supply above low-operating level
    logic idle_pin;
    logic [1:0] in_pins;
    modport src(output batt_crank, batt_uv, batt_op, logic_uv, logic_lop, idle_pin, in_pins);
    modport dst(input batt_crank, batt_uv, batt_op, logic_uv, logic_lop, idle_pin, in_pins);
endinterface

//--- hw/scg_sync.sv
`timescale 1ns/1ns
module scg_sync
    import scg_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] raw,
    scg_sync_if.src sync
);
    logic [WIDTH-1:0] st1, st2, st3, stable;
    logic [WIDTH-1:0] next_stable;

    // a change is accepted once stages two and three agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < WIDTH; i++) begin
            if (st2[i] == st3[i]) begin
                next_stable[i] = st2[i];
            end
        end
    end

    // three-stage chain; first stage read only by the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st1 <= '0;
            st2 <= '0;
            st3 <= '0;
            stable <= '0;
        end else begin
            st1 <= raw;
            st2 <= st1;
            st3 <= st2;
            stable <= next_stable;
        end
    end

    assign sync.batt_crank = stable[0];
    assign sync.batt_uv = stable[1];
    assign sync.batt_op = stable[2];
    assign sync.logic_uv = stable[3];
    assign sync.logic_lop = stable[4];
    assign sync.idle_pin = stable[5];
    assign sync.in_pins = stable[WIDTH-1:WIDTH-2];
endmodule

//--- hw/scg_gate.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: both supplies undervoltage: no power stages, no serial access, registers reset.
// RULE2: logic supply undervoltage: serial transfers ignored, registers back to defaults.
// RULE3: battery undervoltage disables channels; re-enabled at operating threshold.
// RULE4: battery between thresholds: turning on an off channel is refused.
// RULE5: channels already on between thresholds stay on until command or pin off.
// RULE6: battery at or below 3.0 V: no source switches any channel.
// RULE7: logic undervoltage blocks serial control; pin fallback available above 3.0 V.
// RULE8: battery low and logic undervoltage: pin fallback mode unavailable.
// RULE9: battery low, logic fine: fallback accepted, registers kept, channels off.
// RULE10: host keeps serial clock at 1 MHz in low-operating, low-battery case.
// RULE11: host may use 5 MHz with logic above low-operating or battery operating.
// RULE12: power-on set when a supply is above its threshold and a pin is high.
// RULE13: idle low with an input high enters fallback, driving the mapped channel.
// RULE14: supply flags are synchronised to the internal clock before use.
module scg_gate
    import scg_pkg::*;
#(
    parameter int CH = NUM_CH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic batt_crank_raw,
    input wire logic batt_uv_raw,
    input wire logic batt_op_raw,
    input wire logic logic_uv_raw,
    input wire logic logic_lop_raw,
    input wire logic idle_pin_raw,
    input wire logic [1:0] direct_input_pins,
    input wire logic [CH-1:0] serial_out_req,
    output logic [CH-1:0] channel_on,
    output logic serial_allowed,
    output logic serial_write_allowed,
    output logic [15:0] sclk_max_khz,
    output logic reg_reset,
    output logic fallback_mode,
    output logic fallback_available,
    output logic power_on,
    output scg_batt_t batt_state
);
    scg_sync_if sync ();
    logic [CH-1:0] pin_map, request, next_channel_on;
    logic next_serial_allowed, next_write, next_reg_reset, next_fallback, next_fb_avail, next_power_on;
    logic [15:0] next_sclk;
    scg_batt_t next_batt_state;
    // supply flags, idle pin and direct input pins share one chain
    localparam int SYNC_W = 6 + NUM_IN;

    // all supply flags and pins pass the synchroniser
    scg_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .raw({direct_input_pins, idle_pin_raw, logic_lop_raw, logic_uv_raw,
              batt_op_raw, batt_uv_raw, batt_crank_raw}), // RULE14
        .sync(sync.src)
    );

    // pins mapped onto channels
    function automatic logic [CH-1:0] map_pins(input logic [1:0] pins);
        map_pins = (pins[0] ? CH'(MAP_IN0) : '0) | (pins[1] ? CH'(MAP_IN1) : '0);
    endfunction

    assign pin_map = map_pins(sync.in_pins);

    // supply decode, gating decisions and channel state
    always_comb begin
        next_power_on = power_on;
        if ((sync.batt_op || sync.logic_lop) && (sync.idle_pin || (|sync.in_pins))) begin
            next_power_on = 1'b1; // RULE12
        end
        if (sync.batt_crank) begin
            next_batt_state = SCG_OFF;
        end else if (sync.batt_uv) begin
            next_batt_state = SCG_CRANK;
        end else if (!sync.batt_op) begin
            next_batt_state = SCG_LOW;
        end else begin
            next_batt_state = SCG_OK;
        end
        next_serial_allowed = !sync.logic_uv; // RULE2 RULE7
        next_reg_reset = sync.logic_uv; // RULE1 RULE2
        next_fb_avail = !(sync.batt_crank && sync.logic_uv); // RULE8 RULE7 RULE9
        next_fallback = next_fb_avail && !sync.idle_pin && (|sync.in_pins); // RULE13
        next_write = next_serial_allowed && !next_fallback;
        if (!next_serial_allowed) begin
            next_sclk = SCLK_NONE_KHZ;
        end else if (sync.logic_lop || sync.batt_op) begin
            next_sclk = SCLK_FULL_KHZ; // RULE11
        end else begin
            next_sclk = SCLK_LOW_KHZ; // RULE10
        end
        // register-side requests vanish when serial is blocked
        if (next_fallback) begin
            request = pin_map;
        end else begin
            request = pin_map | (next_write ? serial_out_req : '0);
        end
        if (!power_on) begin
            request = '0;
        end
        case (next_batt_state)
            SCG_OFF: next_channel_on = '0; // RULE6 RULE9 RULE1
            SCG_CRANK: next_channel_on = '0; // RULE3
            SCG_LOW: next_channel_on = channel_on & request; // RULE4 RULE5
            SCG_OK: next_channel_on = request; // RULE3
            default: next_channel_on = '0;
        endcase
    end

    // registered decisions
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel_on <= '0;
            serial_allowed <= 1'b0;
            serial_write_allowed <= 1'b0;
            sclk_max_khz <= SCLK_NONE_KHZ;
            reg_reset <= 1'b1;
            fallback_mode <= 1'b0;
            fallback_available <= 1'b0;
            power_on <= 1'b0;
            batt_state <= SCG_OFF;
        end else begin
            channel_on <= next_channel_on;
            serial_allowed <= next_serial_allowed;
            serial_write_allowed <= next_write;
            sclk_max_khz <= next_sclk;
            reg_reset <= next_reg_reset;
            fallback_mode <= next_fallback;
            fallback_available <= next_fb_avail;
            power_on <= next_power_on;
            batt_state <= next_batt_state;
        end
    end

    // cranking battery forces every channel off
    AST_CRANK_OFF: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        (batt_state == SCG_OFF) |-> (channel_on == '0))
        else $error("channel on at cranking battery");

    // battery undervoltage state keeps channels off
    AST_UV_OFF: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        (batt_state == SCG_CRANK) |-> (channel_on == '0))
        else $error("channel on during battery undervoltage");

    // no new channel between the two battery thresholds
    AST_NO_TURN_ON: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
        (batt_state == SCG_LOW) && $past(batt_state == SCG_LOW) |-> ((channel_on & ~$past(channel_on)) == '0))
        else $error("channel turned on below operating threshold");

    // register reset closes every serial path
    AST_LOGIC_UV: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        reg_reset |-> (!serial_allowed && !serial_write_allowed && sclk_max_khz == SCLK_NONE_KHZ))
        else $error("serial open under logic undervoltage");

    // both supplies down: no fallback, no channel
    AST_BOTH_UV: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
        (batt_state == SCG_OFF) && reg_reset |-> (!fallback_available && channel_on == '0))
        else $error("fallback available with both supplies down");

    // fallback mode is read-only on the serial side
    AST_FB_WRITE: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        fallback_mode |-> !serial_write_allowed && fallback_available)
        else $error("writes allowed in fallback mode");

    // power-on stays set until reset
    AST_POWER_STICKY: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        $past(power_on) |-> power_on)
        else $error("power on dropped");

    // full serial rate with an operating battery
    AST_SCLK_FULL: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
        serial_allowed && batt_state == SCG_OK |-> sclk_max_khz == SCLK_FULL_KHZ)
        else $error("wrong serial clock limit");

    // register reset only follows the synchronised flag
    AST_SYNC_LAG: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        $rose(reg_reset) |-> $past(sync.logic_uv))
        else $error("register reset not from synced flag");

    // both supplies in undervoltage block stages and serial access
    AST_BOTH_UV_BLOCK: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
        sync.batt_uv && sync.logic_uv |=> (channel_on == '0) && !serial_allowed && reg_reset)
        else $error("activity with both supplies in undervoltage");

    // logic undervoltage resets registers and closes serial access
    AST_UV_REGS: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        sync.logic_uv |=> reg_reset && !serial_allowed && !serial_write_allowed)
        else $error("registers not reset under logic undervoltage");

    // registers and serial access return with the logic supply
    AST_UV_RELEASE: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
        !sync.logic_uv |=> !reg_reset && serial_allowed)
        else $error("registers held without logic undervoltage");

    // battery undervoltage disables every channel
    AST_BATT_UV_DROP: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        sync.batt_uv |=> (channel_on == '0))
        else $error("channel on after battery undervoltage");

    // operating battery re-enables pin-driven channels
    AST_REENABLE: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
        sync.batt_op && !sync.batt_uv && !sync.batt_crank && power_on
        |=> ((channel_on & $past(pin_map)) == $past(pin_map)))
        else $error("channel not re-enabled at operating battery");

    // between thresholds a channel still requested by its pin stays on
    AST_LOW_KEEP: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
        !sync.batt_crank && !sync.batt_uv && !sync.batt_op && power_on
        |=> (($past(channel_on) & $past(pin_map) & ~channel_on) == '0))
        else $error("requested channel dropped between thresholds");

    // cranking battery blocks every source
    AST_CRANK_DROP: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
        sync.batt_crank |=> (channel_on == '0))
        else $error("channel on after cranking battery");

    // fallback stays available above the cranking level
    AST_FB_ABOVE: assert property (@(posedge clk) disable iff (!reset_n) // RULE7
        !sync.batt_crank |=> fallback_available)
        else $error("fallback lost above cranking level");

    // cranking battery with logic undervoltage removes fallback
    AST_FB_NONE: assert property (@(posedge clk) disable iff (!reset_n) // RULE8
        sync.batt_crank && sync.logic_uv |=> !fallback_available)
        else $error("fallback offered with both supplies down");

    // cranking battery with good logic supply keeps fallback and registers
    AST_FB_REGS: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
        sync.batt_crank && !sync.logic_uv |=> fallback_available && !reg_reset && (channel_on == '0))
        else $error("wrong state at cranking battery with logic supply");

    // a supply above threshold with a pin high sets power-on
    AST_POWER_SET: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        (sync.batt_op || sync.logic_lop) && (sync.idle_pin || (|sync.in_pins)) |=> power_on)
        else $error("power on not set");

    // without power-on no channel is driven
    AST_NO_POWER: assert property (@(posedge clk) disable iff (!reset_n) // RULE12
        !power_on |=> (channel_on == '0))
        else $error("channel on before power on");

    // idle low with an input high enters fallback
    AST_FB_ENTER: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        !sync.idle_pin && (|sync.in_pins) && !(sync.batt_crank && sync.logic_uv) |=> fallback_mode)
        else $error("fallback not entered");

    // fallback drives only pin-mapped channels
    AST_FB_MAP: assert property (@(posedge clk) disable iff (!reset_n) // RULE13
        fallback_mode |-> ((channel_on & ~map_pins($past(sync.in_pins))) == '0))
        else $error("unmapped channel on in fallback");

    // a synchronised rise needs the raw flag high on two samples
    AST_SYNC_RISE: assert property (@(posedge clk) disable iff (!reset_n) // RULE14
        $rose(sync.logic_uv) |-> $past(logic_uv_raw, 3) && $past(logic_uv_raw, 4))
        else $error("logic flag rose without a settled raw level");
endmodule

//--- bench/scg_host_model.sv
`timescale 1ns/1ns
module scg_host_model
    import scg_pkg::*;
(
    input wire logic [15:0] sclk_max_khz,
    input wire logic [7:0] cmd,
    output logic [7:0] serial_out_req,
    output logic [15:0] host_khz
);
    // host serial clock kept at or under the reported limit
    assign host_khz = (sclk_max_khz > SCLK_FULL_KHZ) ? SCLK_FULL_KHZ : sclk_max_khz;
    // channel on-requests mirror the host's output register image
    assign serial_out_req = cmd;
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import scg_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic crank = 1'b0, uv = 1'b0, op = 1'b1, luv = 1'b0, lop = 1'b1, idle = 1'b1;
    logic [1:0] pins = 2'b00;
    logic [7:0] cmd = 8'h00, req, ch, r;
    logic sa, swa, rr, fm, fa, po;
    logic [15:0] sk, hk;
    scg_batt_t bs;
    int errors = 0, compares = 0;
    // free-running 250 MHz clock
    always #2 clk = ~clk;
    scg_gate scg_gate_inst (.clk(clk), .reset_n(reset_n), .batt_crank_raw(crank), .batt_uv_raw(uv),
        .batt_op_raw(op), .logic_uv_raw(luv), .logic_lop_raw(lop), .idle_pin_raw(idle),
        .direct_input_pins(pins), .serial_out_req(req), .channel_on(ch), .serial_allowed(sa),
        .serial_write_allowed(swa), .sclk_max_khz(sk), .reg_reset(rr), .fallback_mode(fm),
        .fallback_available(fa), .power_on(po), .batt_state(bs));
    scg_host_model scg_host_model_inst (.sclk_max_khz(sk), .cmd(cmd), .serial_out_req(req), .host_khz(hk));
    // vector and flag comparisons
    task automatic chk_v(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_b(input string n, input logic e, input logic g);
        chk_v(n, {15'h0000, e}, {15'h0000, g});
    endtask
    // settle past the synchroniser
    task automatic step();
        repeat (7) @(negedge clk);
    endtask
    // battery level 0 crank, 1 undervoltage, 2 between, 3 operating
    task automatic supply(input int b, input logic l_uv, input logic l_lop);
        @(negedge clk);
        crank = (b == 0);
        uv = (b <= 1);
        op = (b == 3);
        luv = l_uv;
        lop = l_lop;
        step();
    endtask
    task automatic summarize();
        if (errors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end
    // main sequence
    initial begin
        void'($urandom(32'h2bc6));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        supply(3, 1'b0, 1'b1);
        chk_b("power_on", 1'b1, po);
        chk_v("sclk", SCLK_FULL_KHZ, sk);
        chk_v("host_khz", SCLK_FULL_KHZ, hk);
        for (int i = 0; i < 4; i++) begin
            r = 8'($urandom & 32'h7f) | 8'h01;
            cmd = r;
            step();
            chk_v("ch", r, ch);
            supply(2, 1'b0, 1'b0);
            chk_v("ch", r, ch);
            chk_v("sclk", SCLK_LOW_KHZ, sk);
            chk_v("host_khz", SCLK_LOW_KHZ, hk);
            cmd = r | 8'h80;
            step();
            chk_v("ch", r, ch);
            cmd = (r | 8'h80) & 8'hfe;
            step();
            chk_v("ch", r & 8'hfe, ch);
            supply(1, 1'b0, 1'b1);
            chk_v("ch", 16'h0000, ch);
            chk_v("state", {12'h000, SCG_CRANK}, {12'h000, bs});
            supply(3, 1'b0, 1'b1);
            chk_v("ch", cmd, ch);
        end
        supply(1, 1'b1, 1'b0);
        chk_v("ch", 16'h0000, ch);
        chk_b("serial", 1'b0, sa);
        chk_b("reg_reset", 1'b1, rr);
        chk_v("sclk", SCLK_NONE_KHZ, sk);
        supply(0, 1'b0, 1'b1);
        chk_v("ch", 16'h0000, ch);
        chk_b("fb_avail", 1'b1, fa);
        chk_b("reg_reset", 1'b0, rr);
        supply(3, 1'b0, 1'b1);
        idle = 1'b0;
        pins = 2'b01;
        step();
        chk_b("fb_mode", 1'b1, fm);
        chk_v("ch", MAP_IN0, ch);
        chk_b("write", 1'b0, swa);
        supply(3, 1'b1, 1'b1);
        chk_v("ch", MAP_IN0, ch);
        chk_b("serial", 1'b0, sa);
        supply(0, 1'b1, 1'b1);
        chk_b("fb_avail", 1'b0, fa);
        chk_v("ch", 16'h0000, ch);
        supply(3, 1'b0, 1'b1);
        pins = 2'b10;
        step();
        chk_v("ch", MAP_IN1, ch);
        luv = 1'b1;
        @(negedge clk);
        luv = 1'b0;
        step();
        chk_b("reg_reset", 1'b0, rr);
        summarize();
    end
endmodule
